// >>> bench/mcp_load_model.sv
// Loads on the six pulse outputs; they measure the last high and low run of each pin.
// Assumes the pins are sampled on the unit's system clock.
module mcp_load_model (
  input wire logic clock_i,
  input wire logic [5:0] pins_i,
  output logic [15:0] high_len_o [6],
  output logic [15:0] low_len_o [6]
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Run length meters
  logic [15:0] run [6] = '{default: 16'h0000};
  logic [5:0] last = 6'h00;

  // A run is booked only when the level changes, so a constant pin keeps old figures.
  always_ff @(posedge clock_i) begin
    for (int i = 0; i < 6; i++) begin
      if (pins_i[i] == last[i]) begin
        run[i] <= run[i] + 16'h0001;
      end else begin
        run[i] <= 16'h0001;
        if (last[i]) begin
          high_len_o[i] <= run[i];
        end else begin
          low_len_o[i] <= run[i];
        end
      end
    end
    last <= pins_i;
  end
endmodule

// >>> bench/mcp_pwm_top_asserts.sv
// Port checker for the pulse width modulation unit.
// Assumes it is bound into mcp_pwm_top and sees that module's ports only.
module mcp_pwm_chk
  import mcp_pkg::*;
#(
  parameter int CW = COUNT_W
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic [7:0] sfr_rdata_o,
  input wire logic [NUM_CH-1:0] channel_output_o,
  input wire logic single_a_output_o,
  input wire logic single_b_output_o
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================================
  // Shadow state
  logic [7:0] en_q;
  logic [7:0] ctrl_q;
  logic [7:0] addr_q;
  wire [3:0] gate = {4{en_q[BIT_QUAD_EN]}} & ctrl_q[3:0];
  wire pair_comp = gate[0] & gate[1] & en_q[BIT_CH1_SRC] & (ctrl_q[4] ^ ctrl_q[5]);

  function automatic logic is_mapped(input logic [7:0] a);
    return (a >= 8'h99 && a <= 8'h9F) || (a >= 8'hA1 && a <= 8'hA7) || (a >= 8'hA9 && a <= 8'hAE);
  endfunction

  // Copies of the enable and control registers, so gating is judged from writes alone.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      en_q <= 8'h00;
      ctrl_q <= 8'h00;
      addr_q <= 8'h00;
    end else begin
      addr_q <= sfr_addr_i;
      if (sfr_wr_i && sfr_addr_i == ADDR_ENABLE) begin
        en_q <= sfr_wdata_i & ENABLE_USED_MASK;
      end
      if (sfr_wr_i && sfr_addr_i == ADDR_QUAD_CTRL) begin
        ctrl_q <= sfr_wdata_i;
      end
    end
  end

  // ==========================================================================
  // Assertions
  default clocking @(posedge clock_i); endclocking
  default disable iff (sys_rst_i);

  chk_reset_quiet: assert property (
    $fell(sys_rst_i) |=> channel_output_o == 4'h0 && !single_a_output_o && !single_b_output_o)
    else $error("outputs not idle after reset");
  chk_unmapped_zero: assert property (
    !is_mapped(addr_q) |-> sfr_rdata_o == 8'h00) else $error("unmapped read not zero");
  chk_enable_reserved: assert property (
    addr_q == ADDR_ENABLE |-> sfr_rdata_o[7:6] == 2'b00) else $error("reserved bits set");
  chk_write_readback: assert property (
    sfr_wr_i && is_mapped(sfr_addr_i) ##1 !sfr_wr_i && sfr_addr_i == $past(sfr_addr_i)
    |=> sfr_rdata_o == ($past(sfr_wdata_i, 2)
    & (($past(sfr_addr_i, 2) == ADDR_ENABLE) ? ENABLE_USED_MASK : 8'hFF)))
    else $error("register readback wrong");
  chk_read_steady: assert property (
    $stable(sfr_addr_i) && !$past(sfr_wr_i) |=> $stable(sfr_rdata_o))
    else $error("read data moved without cause");
  chk_quad_gating: assert property (
    (channel_output_o & ~$past(gate)) == 4'h0) else $error("disabled channel active");
  chk_single_a_off: assert property (
    !$past(en_q[BIT_SGA_EN]) |-> !single_a_output_o) else $error("generator a active");
  chk_single_b_off: assert property (
    !$past(en_q[BIT_SGB_EN]) |-> !single_b_output_o) else $error("generator b active");
  chk_pair_complement: assert property (
    $past(pair_comp) |-> channel_output_o[0] != channel_output_o[1])
    else $error("paired channels not complementary");
endmodule

bind mcp_pwm_top mcp_pwm_chk #(.CW(CW)) mcp_pwm_chk_i (
  .clock_i(clock_i),
  .sys_rst_i(sys_rst_i),
  .sfr_wr_i(sfr_wr_i),
  .sfr_addr_i(sfr_addr_i),
  .sfr_wdata_i(sfr_wdata_i),
  .sfr_rdata_o(sfr_rdata_o),
  .channel_output_o(channel_output_o),
  .single_a_output_o(single_a_output_o),
  .single_b_output_o(single_b_output_o)
);

// >>> bench/mcp_pwm_top_tb.sv
// Self-checking bench of the pulse width modulation unit.
// Assumes the unit's clock is also its count clock.
module mcp_pwm_top_tb;
  import mcp_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  `define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
    $display("Error at %0t ns: got %h expected %h", $time, got, exp); end end

  // ==========================================================================
  // Signals and state
  logic clock_i = 1'b0, sys_rst_i = 1'b1, sfr_wr_i = 1'b0;
  logic [7:0] sfr_addr_i = 8'h00, sfr_wdata_i = 8'h00, sfr_rdata_o, d;
  logic [3:0] channel_output_o;
  logic single_a_output_o, single_b_output_o;
  logic [15:0] high_len [6], low_len [6], p, c, h, l;
  logic [31:0] seed = 32'h0000_0016;
  int mismatches = 0, comparisons = 0;
  logic [7:0] sg_addr [2][4] = '{'{ADDR_SGA_LOW_LO, ADDR_SGA_LOW_HI, ADDR_SGA_HIGH_LO,
    ADDR_SGA_HIGH_HI}, '{ADDR_SGB_LOW_LO, ADDR_SGB_LOW_HI, ADDR_SGB_HIGH_LO, ADDR_SGB_HIGH_HI}};

  mcp_pwm_top #(.CW(COUNT_W)) mcp_pwm_top_i (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .sfr_wr_i(sfr_wr_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_rdata_o(sfr_rdata_o), .channel_output_o(channel_output_o),
    .single_a_output_o(single_a_output_o), .single_b_output_o(single_b_output_o));
  mcp_load_model mcp_load_model_i (.clock_i(clock_i), .high_len_o(high_len),
    .pins_i({single_b_output_o, single_a_output_o, channel_output_o}), .low_len_o(low_len));

  // ==========================================================================
  // Helpers
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Expected read value: unmapped reads zero, reserved enable bits read zero.
  function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic [7:0] v);
    if ((a >= 8'h99 && a <= 8'h9F) || (a >= 8'hA1 && a <= 8'hA7) || (a >= 8'hA9 && a <= 8'hAE))
      return (a == ADDR_ENABLE) ? (v & 8'h3F) : v;
    return 8'h00;
  endfunction
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge clock_i);
    sfr_wr_i <= 1'b1;
    sfr_addr_i <= a;
    sfr_wdata_i <= v;
    @(posedge clock_i);
    sfr_wr_i <= 1'b0;
  endtask
  // Low byte first, then high; a wrap between the two writes can take a half-written value.
  task automatic wr16(input logic [7:0] a_lo, input logic [7:0] a_hi, input logic [15:0] v);
    wr(a_lo, v[7:0]);
    wr(a_hi, v[15:8]);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock_i);
    sfr_addr_i <= a;
    @(posedge clock_i);
    @(negedge clock_i);
    `CHK(sfr_rdata_o, exp)
  endtask
  task automatic wait_chk(input int n);
    repeat (n) @(posedge clock_i);
    @(negedge clock_i);
  endtask
  task automatic stop_test();
    if (mismatches == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // ==========================================================================
  // Clock, watchdog and main sequence
  initial begin
    forever #25 clock_i = ~clock_i;
  end
  // The whole run needs about a thousand cycles; ten thousand means a hang.
  initial begin
    repeat (10000) @(posedge clock_i);
    mismatches++;
    stop_test();
  end
  initial begin
    repeat (4) @(posedge clock_i);
    sys_rst_i <= 1'b0;
    for (int a = 8'h98; a <= 8'hAF; a++) rd_chk(8'(a), 8'h00);
    for (int a = 8'h98; a <= 8'hAF; a++) begin
      d = 8'(xs());
      wr(8'(a), d);
      rd_chk(8'(a), exp_rd(8'(a), d));
    end
    for (int i = 0; i < 3; i++) begin
      p = 16'(xs() % 17 + 3);
      c = (i == 2) ? p : 16'(xs() % p + 1);
      wr(ADDR_ENABLE, 8'h09);
      wr16(ADDR_PERIOD_LO, ADDR_PERIOD_HI, p);
      wr16(ADDR_CH0_CMP_LO, ADDR_CH0_CMP_HI, c);
      wr16(ADDR_CH1_CMP_LO, ADDR_CH1_CMP_HI, 16'h0000);
      wr16(ADDR_CH2_CMP_LO, ADDR_CH2_CMP_HI, 16'h0000);
      wr16(ADDR_CH3_CMP_LO, ADDR_CH3_CMP_HI, p + 16'h0001);
      wr(ADDR_QUAD_CTRL, 8'hDF);
      // Restart, so a long period left by the sweep never has to run out.
      wr(ADDR_ENABLE, 8'h08);
      wr(ADDR_ENABLE, 8'h09);
      wait_chk(4 * (p + 1) + 4);
      `CHK(high_len[0], c)
      `CHK(low_len[0], p + 16'h0001 - c)
      `CHK(high_len[1], p + 16'h0001 - c)
      `CHK(channel_output_o[3:2], 2'b10)
    end
    wr(ADDR_ENABLE, 8'h00);
    wait_chk(2);
    `CHK(channel_output_o, 4'h0)
    rd_chk(ADDR_PERIOD_LO, p[7:0]);
    wr(ADDR_ENABLE, 8'h06);
    for (int i = 0; i < 3; i++) begin
      h = 16'(xs() % 15 + 1);
      l = 16'(xs() % 15 + 1);
      for (int j = 0; j < 4; j++) wr(sg_addr[0][j], (j < 2) ? l[8*j+:8] : h[8*j-16+:8]);
      for (int j = 0; j < 4; j++) wr(sg_addr[1][j], (j < 2) ? h[8*j+:8] : l[8*j-16+:8]);
      // Restart, so long random times left by the sweep never have to run out.
      wr(ADDR_ENABLE, 8'h00);
      wr(ADDR_ENABLE, 8'h06);
      wait_chk(4 * (h + l) + 40);
      `CHK(high_len[4], h)
      `CHK(low_len[4], l)
      `CHK(high_len[5], l)
      `CHK(low_len[5], h)
    end
    wr(ADDR_SGA_LOW_LO, 8'h20);
    wait_chk(4 * (h + l) + 40);
    `CHK(low_len[4], l)
    wr(ADDR_ENABLE, 8'h00);
    wait_chk(2);
    `CHK({single_b_output_o, single_a_output_o}, 2'b00)
    stop_test();
  end
endmodule

// >>> hw/mcp_pkg.sv
// Constants shared by the multi-channel pulse width modulation unit.
// Assumes an 8-bit special-function register port on the system clock.
package mcp_pkg;

  // ==========================================================================
  // Register offsets on the special-function register port.
  localparam logic [7:0] ADDR_SGA_LOW_LO = 8'h99;
  localparam logic [7:0] ADDR_SGA_LOW_HI = 8'h9A;
  localparam logic [7:0] ADDR_SGA_HIGH_LO = 8'h9B;
  localparam logic [7:0] ADDR_SGA_HIGH_HI = 8'h9C;
  localparam logic [7:0] ADDR_SGB_LOW_LO = 8'h9D;
  localparam logic [7:0] ADDR_SGB_LOW_HI = 8'h9E;
  localparam logic [7:0] ADDR_SGB_HIGH_LO = 8'h9F;
  localparam logic [7:0] ADDR_SGB_HIGH_HI = 8'hA1;
  localparam logic [7:0] ADDR_ENABLE = 8'hA2;
  localparam logic [7:0] ADDR_QUAD_CTRL = 8'hA3;
  localparam logic [7:0] ADDR_CH0_CMP_LO = 8'hA4;
  localparam logic [7:0] ADDR_CH0_CMP_HI = 8'hA5;
  localparam logic [7:0] ADDR_CH1_CMP_LO = 8'hA6;
  localparam logic [7:0] ADDR_CH1_CMP_HI = 8'hA7;
  localparam logic [7:0] ADDR_CH2_CMP_LO = 8'hA9;
  localparam logic [7:0] ADDR_CH2_CMP_HI = 8'hAA;
  localparam logic [7:0] ADDR_CH3_CMP_LO = 8'hAB;
  localparam logic [7:0] ADDR_CH3_CMP_HI = 8'hAC;
  localparam logic [7:0] ADDR_PERIOD_LO = 8'hAD;
  localparam logic [7:0] ADDR_PERIOD_HI = 8'hAE;

  // ==========================================================================
  // Field positions of the enable register and the quad control register.
  localparam int BIT_QUAD_EN = 0;
  localparam int BIT_SGA_EN = 1;
  localparam int BIT_SGB_EN = 2;
  localparam int BIT_CH1_SRC = 3;
  localparam int BIT_CH3_SRC = 5;
  localparam int BIT_CH_EN_LSB = 0;
  localparam int BIT_POL_LSB = 4;
  localparam logic [7:0] ENABLE_USED_MASK = 8'h3F;

  // ==========================================================================
  // Reset values and widths.
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int COUNT_W = 16;
  localparam int NUM_CH = 4;
  localparam int NUM_SG = 2;

  // Byte slots of a single generator, in the order software writes them.
  localparam int SG_LOW_LO = 0;
  localparam int SG_LOW_HI = 1;
  localparam int SG_HIGH_LO = 2;
  localparam int SG_HIGH_HI = 3;

endpackage

// >>> hw/mcp_pwm_top.sv
// Multi-channel pulse width modulation unit: one quad generator with a
// shared counter and two single-channel high/low time generators.
// Assumes the register port is on clock_i; the count clock is clock_i.
module mcp_pwm_top
  import mcp_pkg::*;
#(
  parameter int CW = COUNT_W
) (
  input wire logic clock_i,
  input wire logic sys_rst_i,
  input wire logic sfr_wr_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  output logic [7:0] sfr_rdata_o,
  output logic [NUM_CH-1:0] channel_output_o,
  output logic single_a_output_o,
  output logic single_b_output_o
);

  // ==========================================================================
  // Address helpers

  // Offset of byte slot b of single generator g.
  function automatic logic [7:0] sg_addr(input int g, input int b);
    logic [7:0] a;
    a = 8'h00;
    unique case ({g[0], b[1:0]})
      3'h0: a = ADDR_SGA_LOW_LO;
      3'h1: a = ADDR_SGA_LOW_HI;
      3'h2: a = ADDR_SGA_HIGH_LO;
      3'h3: a = ADDR_SGA_HIGH_HI;
      3'h4: a = ADDR_SGB_LOW_LO;
      3'h5: a = ADDR_SGB_LOW_HI;
      3'h6: a = ADDR_SGB_HIGH_LO;
      3'h7: a = ADDR_SGB_HIGH_HI;
    endcase
    return a;
  endfunction

  // Offset of compare byte h (0 low, 1 high) of channel c.
  function automatic logic [7:0] cmp_addr(input int c, input int h);
    logic [7:0] a;
    a = 8'h00;
    unique case ({c[1:0], h[0]})
      3'h0: a = ADDR_CH0_CMP_LO;
      3'h1: a = ADDR_CH0_CMP_HI;
      3'h2: a = ADDR_CH1_CMP_LO;
      3'h3: a = ADDR_CH1_CMP_HI;
      3'h4: a = ADDR_CH2_CMP_LO;
      3'h5: a = ADDR_CH2_CMP_HI;
      3'h6: a = ADDR_CH3_CMP_LO;
      3'h7: a = ADDR_CH3_CMP_HI;
    endcase
    return a;
  endfunction

  // ==========================================================================
  // Software-visible staging registers

  logic [7:0] enable_reg;
  logic [7:0] quad_ctrl;
  logic [7:0] period_stage [2];
  logic [7:0] cmp_stage [NUM_CH][2];
  logic [7:0] sg_stage [NUM_SG][4];

  // Decoded field views of the control registers.
  wire quad_en = enable_reg[BIT_QUAD_EN];
  wire [NUM_SG-1:0] sg_en = {enable_reg[BIT_SGB_EN], enable_reg[BIT_SGA_EN]};
  wire [NUM_CH-1:0] ch_en = quad_ctrl[BIT_CH_EN_LSB +: NUM_CH];
  wire [NUM_CH-1:0] ch_pol = quad_ctrl[BIT_POL_LSB +: NUM_CH];
  wire [2:0] dsrc = enable_reg[BIT_CH3_SRC:BIT_CH1_SRC];
  wire wr_enable = sfr_wr_i && (sfr_addr_i == ADDR_ENABLE);
  wire wr_ctrl = sfr_wr_i && (sfr_addr_i == ADDR_QUAD_CTRL);
  wire wr_per_lo = sfr_wr_i && (sfr_addr_i == ADDR_PERIOD_LO);
  wire wr_per_hi = sfr_wr_i && (sfr_addr_i == ADDR_PERIOD_HI);

  // Write strobes for the compare and single-generator bytes.
  logic [1:0] wr_cmp [NUM_CH];
  logic [3:0] wr_sg [NUM_SG];
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      for (int h = 0; h < 2; h++) begin
        wr_cmp[c][h] = sfr_wr_i && (sfr_addr_i == cmp_addr(c, h));
      end
    end
    for (int g = 0; g < NUM_SG; g++) begin
      for (int b = 0; b < 4; b++) begin
        wr_sg[g][b] = sfr_wr_i && (sfr_addr_i == sg_addr(g, b));
      end
    end
  end

  // Register writes. Period, compare and generator bytes land in staging, so the counters see them
  // only at a period boundary or while disabled; writes are accepted in any enable state.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      enable_reg <= REG_RESET;
      quad_ctrl <= REG_RESET;
      period_stage <= '{REG_RESET, REG_RESET};
      cmp_stage <= '{default: REG_RESET};
      sg_stage <= '{default: REG_RESET};
    end else begin
      if (wr_enable) begin
        enable_reg <= sfr_wdata_i & ENABLE_USED_MASK;
      end
      if (wr_ctrl) begin
        quad_ctrl <= sfr_wdata_i;
      end
      if (wr_per_lo) begin
        period_stage[0] <= sfr_wdata_i;
      end
      if (wr_per_hi) begin
        period_stage[1] <= sfr_wdata_i;
      end
      for (int c = 0; c < NUM_CH; c++) begin
        for (int h = 0; h < 2; h++) begin
          if (wr_cmp[c][h]) begin
            cmp_stage[c][h] <= sfr_wdata_i;
          end
        end
      end
      // byte halves of high and low time
      for (int g = 0; g < NUM_SG; g++) begin
        for (int b = 0; b < 4; b++) begin
          if (wr_sg[g][b]) begin
            sg_stage[g][b] <= sfr_wdata_i;
          end
        end
      end
    end
  end

  // ==========================================================================
  // Read path

  // Read mux; unmapped offsets read zero.
  logic [7:0] next_rdata;
  always_comb begin
    next_rdata = 8'h00;
    if (sfr_addr_i == ADDR_ENABLE) begin
      next_rdata = enable_reg;
    end
    if (sfr_addr_i == ADDR_QUAD_CTRL) begin
      next_rdata = quad_ctrl;
    end
    if (sfr_addr_i == ADDR_PERIOD_LO) begin
      next_rdata = period_stage[0];
    end
    if (sfr_addr_i == ADDR_PERIOD_HI) begin
      next_rdata = period_stage[1];
    end
    for (int c = 0; c < NUM_CH; c++) begin
      for (int h = 0; h < 2; h++) begin
        if (sfr_addr_i == cmp_addr(c, h)) begin
          next_rdata = cmp_stage[c][h];
        end
      end
    end
    for (int g = 0; g < NUM_SG; g++) begin
      for (int b = 0; b < 4; b++) begin
        if (sfr_addr_i == sg_addr(g, b)) begin
          next_rdata = sg_stage[g][b];
        end
      end
    end
  end

  // Registered so the read port is glitch-free; data follows by one clock.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sfr_rdata_o <= 8'h00;
    end else begin
      sfr_rdata_o <= next_rdata;
    end
  end

  // ==========================================================================
  // Quad generator: shared counter

  logic [CW-1:0] qcnt;
  logic [CW-1:0] period_act;
  logic [CW-1:0] cmp_act [NUM_CH];

  wire q_wrap = (qcnt == period_act);

  // one counter for all channels, clocked every system clock.
  // reload at wrap, cleared while disabled.
  // staged values adopted only at the wrap while enabled.
  // While disabled the active copies track staging, so the first period
  // after enable already runs with the programmed values.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      qcnt <= '0;
      period_act <= '0;
      cmp_act <= '{default: '0};
    end else if (!quad_en || q_wrap) begin
      qcnt <= '0;
      period_act <= CW'({period_stage[1], period_stage[0]});
      for (int c = 0; c < NUM_CH; c++) begin
        cmp_act[c] <= CW'({cmp_stage[c][1], cmp_stage[c][0]});
      end
    end else begin
      qcnt <= qcnt + 1'b1;
    end
  end

  // duty source selection for channels 1 to 3.
  // source bit one picks channel 0 compare.
  // Channel 0 has no source bit, so its slot is tied low.
  wire [NUM_CH-1:0] use_ch0 = {dsrc, 1'b0};
  logic [CW-1:0] cmp_eff [NUM_CH];
  logic [NUM_CH-1:0] pulse;
  always_comb begin
    for (int c = 0; c < NUM_CH; c++) begin
      cmp_eff[c] = cmp_act[c];
      if (use_ch0[c]) begin
        cmp_eff[c] = cmp_act[0];
      end
      // pulse ends at the compare count.
      pulse[c] = (qcnt < cmp_eff[c]);
    end
  end

  // polarity one is high from overflow; zero is high from compare.
  // opposite polarity on a shared compare gives complementary pins.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      channel_output_o <= '0;
    end else begin
      channel_output_o <= {NUM_CH{quad_en}} & ch_en & (pulse ^ ~ch_pol);
    end
  end

  // ==========================================================================
  // Single-channel generators

  logic [CW:0] sg_pos [NUM_SG];
  logic [CW-1:0] hi_act [NUM_SG];
  logic [CW-1:0] lo_act [NUM_SG];
  logic [NUM_SG-1:0] sg_pend;
  logic [NUM_SG-1:0] sg_end;
  logic [NUM_SG-1:0] sg_high;
  logic [CW:0] sg_sum [NUM_SG];

  // position runs over high plus low clocks; high phase first.
  always_comb begin
    for (int g = 0; g < NUM_SG; g++) begin
      sg_sum[g] = {1'b0, hi_act[g]} + {1'b0, lo_act[g]};
      sg_end[g] = (sg_sum[g] == '0) || (sg_pos[g] >= sg_sum[g] - 1'b1);
      sg_high[g] = (sg_pos[g] < {1'b0, hi_act[g]});
    end
  end

  // both halves move to the counter together at a period end
  // after the final high-time byte was written. A write in the same cycle
  // as the boundary stays pending, so a fresh byte is never half taken.
  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sg_pos <= '{default: '0};
      hi_act <= '{default: '0};
      lo_act <= '{default: '0};
      sg_pend <= '0;
    end else begin
      for (int g = 0; g < NUM_SG; g++) begin
        if (!sg_en[g]) begin
          sg_pos[g] <= '0;
          hi_act[g] <= CW'({sg_stage[g][SG_HIGH_HI], sg_stage[g][SG_HIGH_LO]});
          lo_act[g] <= CW'({sg_stage[g][SG_LOW_HI], sg_stage[g][SG_LOW_LO]});
          sg_pend[g] <= 1'b0;
        end else begin
          sg_pend[g] <= wr_sg[g][SG_HIGH_HI] | (sg_pend[g] & ~sg_end[g]);
          if (sg_end[g]) begin
            sg_pos[g] <= '0;
            if (sg_pend[g]) begin
              hi_act[g] <= CW'({sg_stage[g][SG_HIGH_HI], sg_stage[g][SG_HIGH_LO]});
              lo_act[g] <= CW'({sg_stage[g][SG_LOW_HI], sg_stage[g][SG_LOW_LO]});
            end
          end else begin
            sg_pos[g] <= sg_pos[g] + 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      single_a_output_o <= 1'b0;
      single_b_output_o <= 1'b0;
    end else begin
      single_a_output_o <= sg_en[0] & sg_high[0];
      single_b_output_o <= sg_en[1] & sg_high[1];
    end
  end

endmodule
